// ===== src/mls_defs.svh
`ifndef MLS_DEFS_SVH
`define MLS_DEFS_SVH
// register byte offsets (bank = addr[11:6], port = addr[5:2])
`define MLS_PCTRL_Z_BANK   6'h00
`define MLS_PCTRL_A_BANK   6'h01
`define MLS_PCTRL_C_BANK   6'h02
`define MLS_GLOBAL_BANK    6'h04
`define MLS_COUNT_BANK     6'h05
`define MLS_GCTRL_Z_IDX    4'h0
`define MLS_GCTRL_A_IDX    4'h1
`define MLS_STATUS_IDX     4'h2
`define MLS_MASK_IDX       4'h3
// port_ctrl_reg_z fields
`define MLS_SPOOF_BIT      0
`define MLS_LOCK_BIT       1
`define MLS_FILT_BIT       2
// port_ctrl_reg_c fields
`define MLS_LRNOFF_BIT     0
// global_ctrl_reg_z fields
`define MLS_CAPMODE_BIT    0
`define MLS_FRZ_EN_BIT     1
`define MLS_FRZ_DROP_BIT   2
`define MLS_FRZ_MIRR_BIT   3
// global_ctrl_reg_a fields
`define MLS_SPFMODE_BIT    0
`define MLS_LOCKDROP_BIT   1
// status / mask bit positions
`define MLS_ST_CAP         0
`define MLS_ST_LOCK        1
`define MLS_ST_SPOOF       2
`define MLS_ST_FRZ         3
`define MLS_ST_FILT        4
// reset values and special figures
`define MLS_CAP_UNLIMITED  8'hFF
`define MLS_CAP_RST        8'hFF
`define MLS_ZERO_RST       8'h00
`define MLS_RESP_OKAY      2'h0
`define MLS_RESP_SLVERR    2'h2
`endif

// ===== src/mls_pkg.sv
package mls_pkg;
  // frame lookup result from the ingress pipeline
  typedef struct packed {
    logic       valid;      // one-cycle request strobe
    logic [3:0] port;       // ingress port
    logic       sa_unicast; // source address is unicast
    logic       hit;        // sa + filtering_id found in table
    logic       hit_static; // matched entry is static
    logic [3:0] hit_port;   // port stored in matched entry
    logic       pmap_zero;  // static entry holds all-zero port map
  } mls_req_t;
  // aging removal of one learned entry
  typedef struct packed {
    logic       valid;
    logic [3:0] port;
  } mls_age_t;
  // per-frame decision
  typedef struct packed {
    logic       valid;
    logic [3:0] port;
    logic       learn_new;
    logic       refresh;
    logic       move;
    logic       drop;
    logic       mirror;
    logic [4:0] viol;       // filter, freeze, spoof, lock, cap
  } mls_dec_t;
endpackage

// ===== src/mls_checker.sv
// Overview of operation
// - full port stops learning; others keep learning
// - cap violation flagged; drop per mode; never learned
// - refresh of known address allowed at cap
// - cap changes live; no flushing on decrease
// - cap zero blocks learning, lookup still done
// - learn off bit: no learning, no drop except filter discard
// - mode zero: drop and skip learning past cap
// - mode one: forward without learning past cap
// - cap 255 means unlimited learning
// - move from locked port is violation, unlearned
// - spoof detect port: any move is violation
// - moves allowed onto non-spoof-detect ports
// - freeze inserts no new entries
// - freeze still refreshes, even at cap zero
// - freeze moves only if learning on, unlocked
// - freeze violation drop/forward, mirror, maskable alert; mirror is set only on dropped frames
// - filter port drops static zero-map match
// - filter discard raises its own indication
// - reset leaves learning bounded only by table
// - learning off skips the cap check
// - static entries never altered by learning
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mls_defs.svh"

module mls_checker #(
  parameter int NPORT = 16, // ingress ports
  parameter int CNT_W = 12  // learned-count width, must exceed 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // axi4-lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // axi4-lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // frame lookup and aging events
  input  wire mls_pkg::mls_req_t req,
  input  wire mls_pkg::mls_age_t age,
  // per-frame decision and alert
  output mls_pkg::mls_dec_t     dec,
  output logic                  alert
);
  import mls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [NPORT-1:0]  spoof_detect_ctrl_ff;  // per-port spoof detection
  logic [NPORT-1:0]  lock_en_ff;            // per-port locking
  logic [NPORT-1:0]  filt_en_ff;            // per-port source filtering
  logic [NPORT-1:0]  learn_off_bit_ff;      // per-port learning disable
  logic [7:0]        learn_cap_count_ff [NPORT]; // per-port cap
  logic [CNT_W-1:0]  cnt_ff [NPORT];        // learned addresses per port
  logic [3:0]        gz_ff;                 // global_ctrl_reg_z
  logic [1:0]        ga_ff;                 // global_ctrl_reg_a
  logic [4:0]        status_ff;             // sticky violation flags
  logic [4:0]        mask_ff;               // alert enables

  ////////////////////////////////////////////////////////////////////////////
  // axi write decode
  logic       awready_ff;
  logic       wready_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  wire        wr_fire    = s_axi_awvalid & awready_ff;      // both taken together
  wire  [5:0] wr_bank    = s_axi_awaddr[11:6];
  wire  [3:0] wr_idx     = s_axi_awaddr[5:2];
  wire        wr_lane0   = wr_fire & s_axi_wstrb[0];
  wire        wr_port_ok = 32'(wr_idx) < NPORT;
  wire        wr_glob    = wr_bank == `MLS_GLOBAL_BANK;
  wire        wr_gz      = wr_lane0 & wr_glob & (wr_idx == `MLS_GCTRL_Z_IDX);
  wire        wr_ga      = wr_lane0 & wr_glob & (wr_idx == `MLS_GCTRL_A_IDX);
  wire        wr_st      = wr_lane0 & wr_glob & (wr_idx == `MLS_STATUS_IDX);
  wire        wr_mk      = wr_lane0 & wr_glob & (wr_idx == `MLS_MASK_IDX);
  wire        wr_mapped  = (wr_glob & (wr_idx <= `MLS_MASK_IDX))
                         | (wr_port_ok & (wr_bank <= `MLS_PCTRL_C_BANK))
                         | (wr_port_ok & (wr_bank == `MLS_COUNT_BANK));
  wire  [7:0] wbyte      = s_axi_wdata[7:0];

  // accept address and data in the same cycle, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `MLS_RESP_OKAY;
    end else begin
      awready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
      wready_ff  <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_mapped ? `MLS_RESP_OKAY : `MLS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // frame decision logic, one request per cycle
  wire [3:0]       p         = req.port;
  wire [3:0]       hp        = req.hit_port;
  wire [7:0]       cap       = learn_cap_count_ff[p];
  wire             en        = req.valid & ~learn_off_bit_ff[p];
  wire             freeze    = gz_ff[`MLS_FRZ_EN_BIT];
  wire             unlimited = cap == `MLS_CAP_UNLIMITED;
  wire             at_cap    = ~unlimited
                             & (cnt_ff[p] >= {{(CNT_W-8){1'b0}}, cap});
  wire             dyn_hit   = req.hit & ~req.hit_static;
  wire             same      = dyn_hit & (hp == p);
  wire             other     = dyn_hit & (hp != p);
  wire             filt_v    = req.valid & filt_en_ff[p] & req.hit
                             & req.hit_static & req.pmap_zero;
  wire             lock_v    = en & other & lock_en_ff[hp];
  wire             spoof_v   = en & other & spoof_detect_ctrl_ff[p];
  wire             frz_new   = en & freeze & req.sa_unicast & ~req.hit;
  wire             frz_move  = en & freeze & other & ~lock_v & ~spoof_v
                             & (cap == `MLS_ZERO_RST);
  wire             frz_v     = frz_new | frz_move;
  wire             cand      = en & ~freeze & req.sa_unicast & ~filt_v
                             & (~req.hit | (other & ~lock_v & ~spoof_v));
  wire             cap_v     = cand & at_cap;
  wire             learn_new = cand & ~req.hit & ~at_cap;
  wire             move      = (cand & req.hit & ~at_cap)
                             | (en & freeze & other & ~lock_v & ~spoof_v & ~frz_move);
  wire             refresh   = en & same;
  wire             cap_drop  = cap_v & ~gz_ff[`MLS_CAPMODE_BIT];
  wire             frz_drop  = frz_v & gz_ff[`MLS_FRZ_DROP_BIT];
  wire             drop      = filt_v | cap_drop | frz_drop
                             | (lock_v & ga_ff[`MLS_LOCKDROP_BIT])
                             | (spoof_v & ga_ff[`MLS_SPFMODE_BIT]);
  wire             mirror    = frz_drop & gz_ff[`MLS_FRZ_MIRR_BIT];
  wire [4:0]       viol      = {filt_v, frz_v, spoof_v, lock_v, cap_v};
  mls_dec_t        dec_ff;

  // register the decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_ff <= '0;
    end else begin
      dec_ff.valid     <= req.valid;
      dec_ff.port      <= p;
      dec_ff.learn_new <= learn_new;
      dec_ff.refresh   <= refresh;
      dec_ff.move      <= move;
      dec_ff.drop      <= drop;
      dec_ff.mirror    <= mirror;
      dec_ff.viol      <= viol;
    end
  end
  assign dec = dec_ff;

  ////////////////////////////////////////////////////////////////////////////
  // per-port configuration and learned counters
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      wire             wsel   = wr_lane0 & (32'(wr_idx) == gi);
      wire             inc    = (learn_new | move) & (32'(p) == gi);
      wire             dec_o  = move & (32'(hp) == gi);
      wire             dec_a  = age.valid & (32'(age.port) == gi);
      logic [CNT_W-1:0] nxt_cnt;

      // learned count: +1 on learn or move in, -1 on move out or aging
      always_comb begin
        nxt_cnt = cnt_ff[gi];
        if (inc & ~(dec_o | dec_a)) begin
          if (~&cnt_ff[gi]) nxt_cnt = cnt_ff[gi] + CNT_W'(1);
        end else if (~inc & (dec_o ^ dec_a)) begin
          if (|cnt_ff[gi]) nxt_cnt = cnt_ff[gi] - CNT_W'(1);
        end else if (~inc & dec_o & dec_a) begin
          nxt_cnt = (cnt_ff[gi] > 2) ? cnt_ff[gi] - CNT_W'(2) : '0;
        end
      end

      // software writes port fields; lowering the cap leaves entries alone
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          spoof_detect_ctrl_ff[gi] <= 1'b0;
          lock_en_ff[gi]           <= 1'b0;
          filt_en_ff[gi]           <= 1'b0;
          learn_off_bit_ff[gi]     <= 1'b0;
          learn_cap_count_ff[gi]   <= `MLS_CAP_RST;
          cnt_ff[gi]               <= '0;
        end else begin
          cnt_ff[gi] <= nxt_cnt;
          if (wsel & (wr_bank == `MLS_PCTRL_Z_BANK)) begin
            spoof_detect_ctrl_ff[gi] <= wbyte[`MLS_SPOOF_BIT];
            lock_en_ff[gi]           <= wbyte[`MLS_LOCK_BIT];
            filt_en_ff[gi]           <= wbyte[`MLS_FILT_BIT];
          end
          if (wsel & (wr_bank == `MLS_PCTRL_A_BANK)) begin
            learn_cap_count_ff[gi] <= wbyte;
          end
          if (wsel & (wr_bank == `MLS_PCTRL_C_BANK)) begin
            learn_off_bit_ff[gi] <= wbyte[`MLS_LRNOFF_BIT];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // global control, sticky status and alert
  wire [4:0] nxt_status = (status_ff & ~(wr_st ? wbyte[4:0] : 5'h00)) | viol;
  logic      alert_ff;

  // set wins over the write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gz_ff     <= 4'h0;
      ga_ff     <= 2'h0;
      status_ff <= 5'h00;
      mask_ff   <= 5'h00;
      alert_ff  <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      alert_ff  <= |(nxt_status & mask_ff);
      if (wr_gz) gz_ff <= wbyte[3:0];
      if (wr_ga) ga_ff <= wbyte[1:0];
      if (wr_mk) mask_ff <= wbyte[4:0];
    end
  end
  assign alert = alert_ff;

  ////////////////////////////////////////////////////////////////////////////
  // axi read path
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  wire         rd_fire  = s_axi_arvalid & arready_ff;
  wire  [5:0]  rd_bank  = s_axi_araddr[11:6];
  wire  [3:0]  rd_idx   = s_axi_araddr[5:2];
  wire         rd_pok   = 32'(rd_idx) < NPORT;
  wire         rd_glob  = rd_bank == `MLS_GLOBAL_BANK;
  wire  [31:0] rd_pz    = {29'h0, filt_en_ff[rd_idx], lock_en_ff[rd_idx],
                           spoof_detect_ctrl_ff[rd_idx]};
  wire  [31:0] rd_pa    = {24'h0, learn_cap_count_ff[rd_idx]};
  wire  [31:0] rd_pc    = {31'h0, learn_off_bit_ff[rd_idx]};
  wire  [31:0] rd_cnt   = {{(32-CNT_W){1'b0}}, cnt_ff[rd_idx]};
  wire  [31:0] rd_g     = (rd_idx == `MLS_GCTRL_Z_IDX) ? {28'h0, gz_ff}
                        : (rd_idx == `MLS_GCTRL_A_IDX) ? {30'h0, ga_ff}
                        : (rd_idx == `MLS_STATUS_IDX)  ? {27'h0, status_ff}
                        : {27'h0, mask_ff};
  wire         rd_gok   = rd_glob & (rd_idx <= `MLS_MASK_IDX);
  wire         rd_ok    = rd_gok | (rd_pok & ((rd_bank <= `MLS_PCTRL_C_BANK)
                        | (rd_bank == `MLS_COUNT_BANK)));
  wire  [31:0] rd_val   = ~rd_ok                          ? 32'h0000_0000
                        : rd_gok                          ? rd_g
                        : (rd_bank == `MLS_PCTRL_Z_BANK)  ? rd_pz
                        : (rd_bank == `MLS_PCTRL_A_BANK)  ? rd_pa
                        : (rd_bank == `MLS_PCTRL_C_BANK)  ? rd_pc
                        : rd_cnt;

  // one read at a time, data the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `MLS_RESP_OKAY;
    end else begin
      arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_val;
        rresp_ff  <= rd_ok ? `MLS_RESP_OKAY : `MLS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  full_port_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_v |=> dec.valid && dec.viol[0] && !dec.learn_new && !dec.move)
    else $error("learning past cap");
  cap_mode_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap_v && !gz_ff[`MLS_CAPMODE_BIT]) |=> dec.drop)
    else $error("cap violation not dropped in mode zero");
  cap_mode_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap_v && gz_ff[`MLS_CAPMODE_BIT] && !filt_v && !lock_v && !spoof_v) |=> !dec.drop)
    else $error("cap violation dropped in mode one");
  learn_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req.valid && learn_off_bit_ff[p] && !filt_v) |=> !dec.drop && !dec.learn_new
      && !dec.refresh && dec.viol[3:0] == 4'h0)
    else $error("learning-off port learned or dropped");
  unlimited_learn_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req.valid && !learn_off_bit_ff[p] && unlimited && !freeze && req.sa_unicast
      && !req.hit && !filt_v) |=> dec.learn_new && !dec.drop)
    else $error("unlimited port did not learn");
  lock_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_v |=> dec.viol[1] && !dec.move
      && (!$past(ga_ff[`MLS_LOCKDROP_BIT]) || dec.drop))
    else $error("locked station moved");
  freeze_no_new_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req.valid && freeze) |=> !dec.learn_new)
    else $error("new entry during freeze");
  freeze_refresh_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (en && freeze && same) |=> dec.refresh && !dec.move && !dec.learn_new)
    else $error("no refresh during freeze");
  filter_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    filt_v |=> dec.drop && dec.viol[4] && status_ff[`MLS_ST_FILT])
    else $error("filtered frame not dropped or flagged");
  static_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req.valid && req.hit && req.hit_static) |=> !dec.move && !dec.refresh
      && !dec.learn_new)
    else $error("static entry altered");
  sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_ff[`MLS_ST_CAP] && !(wr_st && wbyte[`MLS_ST_CAP])) |=> status_ff[`MLS_ST_CAP])
    else $error("sticky flag lost");

endmodule

// ===== dv/mls_table_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// stand-in for the ingress parser and the hashed bridging table
module mls_table_model
  import mls_pkg::*;
(
  // clock
  input  wire logic              aclk,
  // lookup and aging towards the checker
  output mls_pkg::mls_req_t      req,
  output mls_pkg::mls_age_t      age,
  input  wire mls_pkg::mls_dec_t dec
);
  logic [6:0] ent [16];  // per key: valid, static, zero map, port[3:0]
  logic [3:0] last_key;  // key of the frame in flight
  initial begin
    req      = '0;
    age      = '0;
    last_key = 4'h0;
    ent      = '{default: 7'h00};
  end
  ////////////////////////////////////////////////////////////////////////////
  // one lookup strobe built from the stored entry
  task automatic send(input logic [3:0] port, input logic [3:0] key);
    // two idle edges first, so the last decision has reached the table
    repeat (2) @(posedge aclk);
    last_key <= key;
    req      <= '{1'b1, port, 1'b1, ent[key][6], ent[key][5], ent[key][3:0], ent[key][4]};
    @(posedge aclk);
    req      <= '0;
  endtask
  // one aged-out entry of a port
  task automatic age_out(input logic [3:0] port);
    @(posedge aclk);
    age <= '{1'b1, port};
    @(posedge aclk);
    age <= '0;
  endtask
  // software-owned entry
  task automatic put_static(input logic [3:0] key, input logic [3:0] port, input logic pz);
    ent[key] <= {2'b11, pz, port};
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // table follows the checker: new and moved stations get the ingress port
  always @(posedge aclk) begin
    if (dec.valid && (dec.learn_new || dec.move)) begin
      ent[last_key] <= {3'b100, dec.port};
    end
  end
endmodule

// ===== dv/mls_checker_tb_top.sv
`timescale 1ns/1ps
module mls_checker_tb_top;
  import mls_pkg::*;
  logic        aclk, aresetn;                    // clock, reset
  logic [11:0] awaddr, araddr;                   // axi addresses
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;                     // axi data
  logic [1:0]  bresp, rresp;                     // axi responses
  mls_req_t    req;                              // lookup from model
  mls_age_t    age;                              // aging from model
  mls_dec_t    dec;                              // decision
  logic        alert;                            // masked alert
  int          n_fail, checked;                  // tallies
  ////////////////////////////////////////////////////////////////////////////
  mls_checker dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .req(req), .age(age), .dec(dec), .alert(alert));
  mls_table_model m (.aclk(aclk), .req(req), .age(age), .dec(dec));
  // free-running clock, 8 ns
  always #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  // compare tasks
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_dec(input logic [3:0] p, input logic [9:0] e);
    checked++;
    if (dec !== {1'b1, p, e}) begin
      n_fail++;
      $display("[ERR] dec expected %h seen %h", {1'b1, p, e}, dec);
    end
  endtask
  // axi4-lite write: both channels, then response
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready  <= 1'b0;
    chk_word("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  // axi4-lite read with data and response compare
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready  <= 1'b0;
    chk_word("rresp", {30'h0, er}, {30'h0, rresp});
    chk_word("rdata", ed, rdata);
  endtask
  // one frame through the model, decision one cycle later
  // flags: learn_new refresh move drop mirror viol[4:0]
  task automatic frame(input logic [3:0] p, input logic [3:0] k, input logic [9:0] e);
    m.send(p, k);
    #1;
    chk_dec(p, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    axi_rd(12'h040, 32'h0000_00FF, 2'h0);
    axi_rd(12'h108, 32'h0000_0000, 2'h0);
    axi_rd(12'h200, 32'h0000_0000, 2'h2);
    axi_wr(12'h200, 32'h0000_0001, 2'h2);
    $display("test reset done");
  endtask
  task automatic t_cap;
    axi_wr(12'h044, 32'h2, 2'h0);
    frame(4'h1, 4'h1, 10'h200);
    frame(4'h1, 4'h2, 10'h200);
    frame(4'h1, 4'h3, 10'h041);
    frame(4'h1, 4'h1, 10'h100);
    frame(4'h2, 4'h4, 10'h200);
    axi_rd(12'h144, 32'h2, 2'h0);
    axi_wr(12'h100, 32'h1, 2'h0);
    frame(4'h1, 4'h3, 10'h001);
    axi_wr(12'h044, 32'h3, 2'h0);
    frame(4'h1, 4'h3, 10'h200);
    axi_wr(12'h044, 32'h1, 2'h0);
    frame(4'h1, 4'h5, 10'h001);
    axi_rd(12'h144, 32'h3, 2'h0);
    m.age_out(4'h1);
    axi_rd(12'h144, 32'h2, 2'h0);
    axi_wr(12'h044, 32'h0, 2'h0);
    frame(4'h1, 4'h1, 10'h100);
    frame(4'h1, 4'h6, 10'h001);
    axi_rd(12'h108, 32'h01, 2'h0);
    axi_wr(12'h108, 32'h01, 2'h0);
    axi_rd(12'h108, 32'h00, 2'h0);
    $display("test cap done");
  endtask
  task automatic t_learn_off;
    axi_wr(12'h100, 32'h0, 2'h0);
    axi_wr(12'h08C, 32'h1, 2'h0);
    axi_wr(12'h04C, 32'h0, 2'h0);
    frame(4'h3, 4'h7, 10'h000);
    $display("test learn_off done");
  endtask
  task automatic t_lock_spoof;
    axi_wr(12'h104, 32'h3, 2'h0);
    axi_wr(12'h010, 32'h2, 2'h0);
    frame(4'h4, 4'h8, 10'h200);
    frame(4'h5, 4'h8, 10'h042);
    axi_wr(12'h018, 32'h1, 2'h0);
    frame(4'h6, 4'h4, 10'h044);
    frame(4'h7, 4'h4, 10'h080);
    $display("test lock_spoof done");
  endtask
  task automatic t_freeze;
    axi_wr(12'h108, 32'h1F, 2'h0);
    axi_wr(12'h10C, 32'h08, 2'h0);
    axi_wr(12'h100, 32'hE, 2'h0);
    frame(4'h7, 4'h9, 10'h068);
    @(posedge aclk);
    #1;
    chk_word("alert", 32'h1, {31'h0, alert});
    frame(4'h7, 4'h4, 10'h100);
    frame(4'h2, 4'h4, 10'h080);
    frame(4'h5, 4'h8, 10'h042);
    frame(4'h1, 4'h4, 10'h068);
    axi_wr(12'h100, 32'h0, 2'h0);
    $display("test freeze done");
  endtask
  task automatic t_filter;
    axi_wr(12'h020, 32'h4, 2'h0);
    m.put_static(4'hA, 4'h0, 1'b1);
    m.put_static(4'hB, 4'h3, 1'b0);
    frame(4'h8, 4'hA, 10'h050);
    frame(4'h9, 4'hB, 10'h000);
    axi_rd(12'h108, 32'h1A, 2'h0);
    $display("test filter done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence: reset held 4 cycles, then the scenarios
  initial begin
    aclk    = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_fail  = 0;
    checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cap();
    t_learn_off();
    t_lock_spoof();
    t_freeze();
    t_filter();
    wrap_up();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule
